// ---- design/rcsp_pkg.sv ----
// Shared constants and carrier types for the serial command/status port.
// Assumes one 10 MHz clock domain; pins arrive asynchronously.
package rcsp_pkg;

  // Word and address widths
  localparam int BYTE_BITS = 8;
  localparam int ADDR_BITS = 11;

  // Clock figures; the checks write their waits as literal cycle counts
  localparam int MCLK_PERIOD_NS = 100;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int SCLK_CYCLES = SCLK_PERIOD_NS / MCLK_PERIOD_NS;

  // Command byte coding
  localparam logic [7:0] NO_OP_BYTE = 8'hFF;
  localparam logic [7:0] MEM_CMD_MASK = 8'hC8;
  localparam logic [7:0] MEM_CMD_MATCH = 8'h08;
  localparam int MEM_OP_LSB = 4;
  localparam int MEM_HI_BITS = 3;

  // Controller state codes shown in the status byte
  localparam logic [4:0] STATE_INIT = 5'h0F;
  localparam logic [4:0] STATE_BUSY = 5'h00;
  localparam logic [4:0] RADIO_OFF_STATE = 5'h11;
  localparam logic [4:0] RADIO_IDLE_STATE = 5'h12;
  localparam logic [4:0] RADIO_RECEIVE_STATE = 5'h13;
  localparam logic [4:0] RADIO_TRANSMIT_STATE = 5'h14;
  localparam logic [4:0] RADIO_SLEEP_STATE = 5'h06;

  // Interrupt source register that takes the ready flags
  localparam logic [10:0] IRQ_SOURCE_ADDR = 11'h337;
  localparam int IRQ_CMD_READY_BIT = 6;
  localparam int IRQ_MEM_READY_BIT = 1;

  typedef enum logic [1:0] {
    OP_RANDOM_WRITE = 2'b00,
    OP_BLOCK_WRITE = 2'b01,
    OP_RANDOM_READ = 2'b10,
    OP_BLOCK_READ = 2'b11
  } rcsp_mem_op_type;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } rcsp_pins_type;

  localparam rcsp_pins_type PINS_IDLE = '{cs_n: 1'h1, sclk: 1'h0, mosi: 1'h0};

  // Status byte: bit 7 down to bit 0
  typedef struct packed {
    logic mem_ready;
    logic irq_pending;
    logic cmd_accept;
    logic [4:0] controller_state;
  } rcsp_status_type;

  typedef struct packed {
    logic we;
    logic re;
    logic [10:0] addr;
    logic [7:0] wdata;
  } rcsp_mem_req_type;

  localparam rcsp_mem_req_type MEM_REQ_IDLE = '{1'h0, 1'h0, 11'h000, 8'h00};

  // Memory commands are 00xx1xxx
  function automatic logic is_mem_cmd(input logic [7:0] b);
    return (b & MEM_CMD_MASK) == MEM_CMD_MATCH;
  endfunction : is_mem_cmd

endpackage : rcsp_pkg

// ---- design/rcsp_pin_sync.sv ----
// Two-stage synchroniser for the chip select, clock and data pins.
// Assumes the pins are asynchronous to mclk; outputs are clean levels.
`timescale 1ns/100ps
`default_nettype none
module rcsp_pin_sync (
  input wire logic mclk,
  input wire logic rst,
  input wire rcsp_pkg::rcsp_pins_type pins_in,
  output var rcsp_pkg::rcsp_pins_type pins_out
);
  import rcsp_pkg::*;

  rcsp_pins_type meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk) begin
    if (rst) begin
      meta_reg <= PINS_IDLE;
      pins_out <= PINS_IDLE;
    end else begin
      meta_reg <= pins_in;
      pins_out <= meta_reg;
    end
  end

endmodule : rcsp_pin_sync
`default_nettype wire

// ---- design/rcsp_cmd_queue.sv ----
// One-entry queue of radio commands waiting for the processor.
// Assumes push and pop are single-cycle pulses on mclk.
`timescale 1ns/100ps
`default_nettype none
module rcsp_cmd_queue (
  input wire logic mclk,
  input wire logic rst,
  input wire logic push,
  input wire logic [7:0] push_byte,
  input wire logic pop,
  output var logic full_reg,
  output var logic [7:0] byte_reg
);
  import rcsp_pkg::*;

  // A push in the pop cycle refills at once; set wins over clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      full_reg <= 1'h0;
      byte_reg <= 8'h00;
    end else if (push && (!full_reg || pop)) begin
      full_reg <= 1'h1;
      byte_reg <= push_byte;
    end else if (pop) begin
      full_reg <= 1'h0;
    end
  end

endmodule : rcsp_cmd_queue
`default_nettype wire

// ---- design/rcsp_port.sv ----
// Serial command/status port: slave side of a four-wire serial link.
// Assumes processor, memory and status inputs share mclk; pins do not.
`timescale 1ns/100ps
`default_nettype none
module rcsp_port (
  input wire logic mclk,
  input wire logic rst,
  input wire rcsp_pkg::rcsp_pins_type spi_pins,
  input wire logic [4:0] controller_state,
  input wire logic host_irq_pin,
  input wire logic mem_ready,
  input wire logic cmd_take,
  input wire logic [7:0] mem_rdata,
  output var logic miso,
  output var logic miso_oe,
  output var rcsp_pkg::rcsp_mem_req_type mem_req,
  output var logic cmd_valid,
  output var logic [7:0] cmd_byte,
  output var logic cmd_ready_flag,
  output var logic mem_ready_flag
);
  import rcsp_pkg::*;

  rcsp_pins_type pins_s;
  logic sclk_d_reg;
  logic cs_n_d_reg;
  logic active;
  logic rise;
  logic fall;
  logic cs_fall;
  logic byte_done;
  logic [7:0] rx_full;
  logic [2:0] bit_cnt_reg;
  logic [7:0] rx_reg;
  logic [7:0] sh_reg;
  logic [7:0] next_tx_reg;
  logic [1:0] byte_cnt_reg;
  logic phase_reg;
  logic mem_mode_reg;
  rcsp_mem_op_type op_reg;
  logic [2:0] hi_reg;
  logic [7:0] lo_prev_reg;
  logic [10:0] addr_reg;
  logic [10:0] eff_addr;
  logic rd_pend_reg;
  logic want_read;
  logic want_write;
  logic cmd_push;
  rcsp_status_type status;

  // Pins are retimed before anything looks at them
  rcsp_pin_sync u_sync (
    .mclk(mclk),
    .rst(rst),
    .pins_in(spi_pins),
    .pins_out(pins_s)
  );

  // Edge history of the retimed clock and select
  always_ff @(posedge mclk) begin
    if (rst) begin
      sclk_d_reg <= 1'h0;
      cs_n_d_reg <= 1'h1;
    end else begin
      sclk_d_reg <= pins_s.sclk;
      cs_n_d_reg <= pins_s.cs_n;
    end
  end

  // Edge pulses count only inside a selected frame
  assign active = !pins_s.cs_n;
  assign rise = active && pins_s.sclk && !sclk_d_reg;
  assign fall = active && !pins_s.sclk && sclk_d_reg;
  assign cs_fall = active && cs_n_d_reg;
  assign rx_full = {rx_reg[6:0], pins_s.mosi};
  assign byte_done = rise && (bit_cnt_reg == 3'h7);

  // Live status byte
  always_comb begin
    status.mem_ready = mem_ready;
    status.irq_pending = host_irq_pin;
    status.cmd_accept = !cmd_valid;
    status.controller_state = controller_state;
  end

  // Receive shifter and bit counter, MSB arrives first
  always_ff @(posedge mclk) begin
    if (rst || !active) begin
      bit_cnt_reg <= 3'h0;
      rx_reg <= 8'h00;
    end else if (rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_reg <= rx_full;
    end
  end

  // Transmit shifter; the output pin follows sh_reg MSB
  always_ff @(posedge mclk) begin
    if (rst || !active) begin
      sh_reg <= 8'h00;
      miso <= 1'h0;
    end else if (cs_fall) begin
      sh_reg <= status;
      miso <= status.mem_ready;
    end else if (fall && bit_cnt_reg == 3'h0) begin
      sh_reg <= next_tx_reg;
      miso <= next_tx_reg[7];
    end else if (fall) begin
      sh_reg <= {sh_reg[6:0], 1'h0};
      miso <= sh_reg[6];
    end
  end

  // Pin driven only while selected
  always_ff @(posedge mclk) begin
    if (rst) begin
      miso_oe <= 1'h0;
    end else begin
      miso_oe <= active;
    end
  end

  // Frame progress: byte index saturates at two, phase alternates
  always_ff @(posedge mclk) begin
    if (rst || !active) begin
      byte_cnt_reg <= 2'h0;
      phase_reg <= 1'h0;
    end else if (byte_done) begin
      if (byte_cnt_reg != 2'h2) begin
        byte_cnt_reg <= byte_cnt_reg + 2'h1;
      end
      phase_reg <= !phase_reg;
    end
  end

  // First byte decides the frame; later bytes of a radio frame are ignored
  always_ff @(posedge mclk) begin
    if (rst || !active) begin
      mem_mode_reg <= 1'h0;
      op_reg <= OP_RANDOM_WRITE;
      hi_reg <= 3'h0;
    end else if (byte_done && byte_cnt_reg == 2'h0 && is_mem_cmd(rx_full)) begin
      mem_mode_reg <= 1'h1;
      op_reg <= rcsp_mem_op_type'(rx_full[MEM_OP_LSB +: 2]);
      hi_reg <= rx_full[MEM_HI_BITS-1:0];
    end
  end

  // Radio command push; an all-ones byte is never a command
  assign cmd_push = byte_done && byte_cnt_reg == 2'h0
    && !is_mem_cmd(rx_full) && rx_full != NO_OP_BYTE;

  // Queue drains when the processor starts the held command
  rcsp_cmd_queue u_queue (
    .mclk(mclk),
    .rst(rst),
    .push(cmd_push),
    .push_byte(rx_full),
    .pop(cmd_take),
    .full_reg(cmd_valid),
    .byte_reg(cmd_byte)
  );

  // Block modes run a counter; random modes use the last address byte
  assign eff_addr = (op_reg == OP_BLOCK_WRITE || op_reg == OP_BLOCK_READ)
    ? addr_reg : {hi_reg, lo_prev_reg};

  // Memory action on completed data bytes of a memory frame, from the third byte; random write on every other byte
  always_comb begin
    want_write = 1'h0;
    want_read = 1'h0;
    if (byte_done && mem_mode_reg && byte_cnt_reg == 2'h2) begin
      unique case (op_reg)
        OP_BLOCK_WRITE: want_write = 1'h1;
        OP_RANDOM_WRITE: want_write = !phase_reg;
        OP_BLOCK_READ: want_read = 1'h1;
        OP_RANDOM_READ: want_read = 1'h1;
      endcase
    end
  end

  // Address tracking; block address wraps at eleven bits
  always_ff @(posedge mclk) begin
    if (rst || !active) begin
      addr_reg <= 11'h000;
      lo_prev_reg <= 8'h00;
    end else if (byte_done && mem_mode_reg) begin
      if (byte_cnt_reg == 2'h1) begin
        addr_reg <= {hi_reg, rx_full};
      end else if (want_write || want_read) begin
        addr_reg <= addr_reg + 11'h001;
      end
      if (op_reg == OP_RANDOM_READ || phase_reg) begin
        lo_prev_reg <= rx_full;
      end
    end
  end

  // One-cycle memory strobes; data read lands one cycle later
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_req <= MEM_REQ_IDLE;
    end else begin
      mem_req.we <= want_write;
      mem_req.re <= want_read;
      if (want_write || want_read) begin
        mem_req.addr <= eff_addr;
        mem_req.wdata <= rx_full;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rd_pend_reg <= 1'h0;
    end else begin
      rd_pend_reg <= mem_req.re;
    end
  end

  // Next outgoing byte: memory data when read, else fresh status.
  // Read data is loaded only one mclk cycle before the next falling edge at the bench clock rate.
  always_ff @(posedge mclk) begin
    if (rst) begin
      next_tx_reg <= 8'h00;
    end else if (rd_pend_reg) begin
      next_tx_reg <= mem_rdata;
    end else if (byte_done && !want_read) begin
      next_tx_reg <= status;
    end
  end

  // Ready flags for the interrupt source register
  always_ff @(posedge mclk) begin
    if (rst) begin
      cmd_ready_flag <= 1'h0;
      mem_ready_flag <= 1'h0;
    end else begin
      cmd_ready_flag <= !cmd_valid;
      mem_ready_flag <= mem_ready;
    end
  end

  // Output is off one cycle after select is seen high
  a_miso_off_idle: assert property (@(posedge mclk) disable iff (rst)
    pins_s.cs_n |=> !miso_oe && !miso)
    else $error("miso driven while deselected");

  // Status MSB presented on select, before any clock edge
  a_status_msb_first: assert property (@(posedge mclk) disable iff (rst)
    cs_fall |=> miso == $past(status.mem_ready) && miso_oe)
    else $error("status MSB not presented at select");

  // Received bits shift in MSB first on rising edges
  a_rx_capture: assert property (@(posedge mclk) disable iff (rst)
    rise && bit_cnt_reg != 3'h7 |=> rx_reg == {$past(rx_reg[6:0]), $past(pins_s.mosi)})
    else $error("rx bit not captured on rising edge");

  // Output moves only on falling edges within a byte
  a_tx_shift_fall: assert property (@(posedge mclk) disable iff (rst)
    fall && bit_cnt_reg != 3'h0 |=> miso == $past(sh_reg[6]))
    else $error("tx bit not shifted on falling edge");

  // Output holds between edges while selected
  a_tx_steady: assert property (@(posedge mclk) disable iff (rst)
    active && !fall && !cs_fall && $past(active) |=> $stable(miso))
    else $error("miso changed without falling edge");

  // Radio command lands in the queue one cycle after its last bit
  a_cmd_queued: assert property (@(posedge mclk) disable iff (rst)
    cmd_push && !cmd_valid |=> cmd_valid && cmd_byte == $past(rx_full) && !status.cmd_accept)
    else $error("radio command not queued");

  // Memory command never reaches the radio queue
  a_mem_not_queued: assert property (@(posedge mclk) disable iff (rst)
    byte_done && byte_cnt_reg == 2'h0 && is_mem_cmd(rx_full) && !cmd_valid |=> !cmd_valid)
    else $error("memory command queued for processor");

  // Queue empties when the processor takes the command
  a_queue_drain: assert property (@(posedge mclk) disable iff (rst)
    cmd_take && cmd_valid && !cmd_push |=> !cmd_valid ##1 cmd_ready_flag)
    else $error("queue did not drain on take");

  // Block write advances the address by one per byte
  a_block_inc: assert property (@(posedge mclk) disable iff (rst)
    want_write && op_reg == OP_BLOCK_WRITE |=> mem_req.we && addr_reg == mem_req.addr + 11'h001)
    else $error("block write address not incremented");

  // Read data reaches the transmit byte two cycles after the request
  a_read_return: assert property (@(posedge mclk) disable iff (rst)
    want_read |=> mem_req.re ##1 1'h1 ##1 next_tx_reg == $past(mem_rdata))
    else $error("read data not loaded for output");

  // Status byte reloaded after each non-read byte
  a_status_reload: assert property (@(posedge mclk) disable iff (rst)
    byte_done && !want_read && !rd_pend_reg |=> next_tx_reg == $past(status))
    else $error("status byte not reloaded");

  // Random write data pairs with the address byte just before it
  a_random_pair: assert property (@(posedge mclk) disable iff (rst)
    want_write && op_reg == OP_RANDOM_WRITE |=> mem_req.addr == {hi_reg, $past(lo_prev_reg)})
    else $error("random write address mismatch");

  // A second byte boundary needs a full SCLK period at least
  a_byte_spacing: assert property (@(posedge mclk) disable iff (rst)
    byte_done |=> !byte_done [*7])
    else $error("byte boundaries too close");

  // Output enable stays on through a selected frame
  a_oe_in_frame: assert property (@(posedge mclk) disable iff (rst)
    active && $past(active) |-> miso_oe)
    else $error("miso not driven while selected");

  // Ready flags follow queue and memory path one cycle late
  a_ready_flags: assert property (@(posedge mclk) disable iff (rst)
    !$past(rst) |-> cmd_ready_flag == !$past(cmd_valid) && mem_ready_flag == $past(mem_ready))
    else $error("ready flags do not follow state");

endmodule : rcsp_port
`default_nettype wire

// ---- sim/rcsp_host_model.sv ----
// Behavioural bus master for the serial port: mode 0, link clock idle low.
// Assumes the caller starts each frame on a falling mclk edge.
`timescale 1ns/100ps
`default_nettype none
module rcsp_host_model (
  output var rcsp_pkg::rcsp_pins_type pins,
  input wire logic miso
);
  import rcsp_pkg::*;
  int half = 400; // Half period of the 800 ns link clock

  initial pins = PINS_IDLE;

  // One select-low frame; bytes go out and come back MSB first
  task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    b = 8'h00;
    pins.cs_n = 1'b0;
    #500; // First rise well after select
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) begin
        pins.mosi = tx[i][k];
        #(half) pins.sclk = 1'b1;
        b[k] = miso; // Sampled on the rising edge
        #(half) pins.sclk = 1'b0;
      end
      rx.push_back(b);
    end
    #400 pins.cs_n = 1'b1;
    pins.mosi = ~pins.mosi; // Released line carries no stale bit
    #400;
  endtask : frame
endmodule : rcsp_host_model
`default_nettype wire

// ---- sim/tb_top.sv ----
// Self-checking bench for the serial command/status port.
// Assumes the host model drives the pins; memory is a stand-in here.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import rcsp_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  rcsp_pins_type pins;
  logic [4:0] st = STATE_INIT;
  logic irq = 1'b0;
  logic mrdy = 1'b0;
  logic take = 1'b0;
  logic [7:0] rdata = 8'h00;
  logic miso, miso_oe, cmd_valid, crf, mrf;
  logic host_miso;
  logic [7:0] cmd_byte;
  rcsp_mem_req_type req;
  logic [10:0] wa[$], ra[$];
  logic [7:0] wd[$], rx[$];
  logic [10:0] a;
  logic [4:0] codes[11] = '{5'h0F, 5'h00, 5'h11, 5'h12, 5'h13, 5'h14, 5'h06, 5'h05,
                            5'h08, 5'h09, 5'h0A};
  logic [7:0] bw[5] = '{8'h18, 8'h19, 8'h1B, 8'h1E, 8'h1F};
  int n_errors = 0;
  int num_checks = 0;

  always #50 mclk = ~mclk;

  rcsp_port dut (
    .mclk(mclk), .rst(rst), .spi_pins(pins), .controller_state(st),
    .host_irq_pin(irq), .mem_ready(mrdy), .cmd_take(take), .mem_rdata(rdata),
    .miso(miso), .miso_oe(miso_oe), .mem_req(req), .cmd_valid(cmd_valid),
    .cmd_byte(cmd_byte), .cmd_ready_flag(crf), .mem_ready_flag(mrf)
  );

  // Undriven line shows the inverse, so a late or missing enable is caught
  assign host_miso = miso_oe ? miso : ~miso;

  rcsp_host_model host (.pins(pins), .miso(host_miso));

  // Synchronous memory stand-in; data is a fixed function of address
  always @(posedge mclk) begin
    if (req.re === 1'b1) begin
      rdata <= req.addr[7:0] ^ 8'h5A;
      ra.push_back(req.addr);
    end
    if (req.we === 1'b1) begin
      wa.push_back(req.addr);
      wd.push_back(req.wdata);
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [7:0] stat(input logic acc);
    return {mrdy, irq, acc, st};
  endfunction : stat

  // Double no-op poll; both bytes carry status, pins quiet afterwards
  task automatic poll(input logic acc);
    host.frame('{NO_OP_BYTE, NO_OP_BYTE}, rx);
    chk(rx[0], stat(acc));
    chk(rx[1], stat(acc));
    chk({miso_oe, miso}, 16'h0000);
  endtask : poll

  task automatic test_done;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (16) @(negedge mclk);
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    // Every state code, with ready and pending bits varied
    foreach (codes[i]) begin
      st = codes[i];
      mrdy = i[0];
      irq = i[1];
      @(negedge mclk);
      poll(1'b1);
      chk(mrf, 16'(mrdy));
    end
    $display("test status done");
    // Radio command behind a busy transition; extra byte ignored
    st = STATE_BUSY;
    mrdy = 1'b1;
    irq = 1'b0;
    poll(1'b1);
    host.frame('{8'h02, 8'h05}, rx);
    chk(cmd_valid, 16'h0001);
    chk(cmd_byte, 16'h0002);
    chk(crf, 16'h0000);
    chk(mrf, 16'h0001);
    poll(1'b0);
    host.frame('{8'h03}, rx);
    chk(cmd_byte, 16'h0002);
    @(negedge mclk);
    take = 1'b1;
    @(negedge mclk);
    take = 1'b0;
    repeat (2) @(negedge mclk);
    chk(cmd_valid, 16'h0000);
    chk(crf, 16'h0001);
    $display("test queue done");
    // Reset in mid-run empties a held command
    host.frame('{8'h04}, rx);
    chk(cmd_valid, 16'h0001);
    rst = 1'b1;
    repeat (3) @(negedge mclk);
    rst = 1'b0;
    chk(cmd_valid, 16'h0000);
    chk(cmd_byte, 16'h0000);
    chk(crf, 16'h0000);
    repeat (2) @(negedge mclk);
    chk(crf, 16'h0001);
    $display("test reset done");
    // Block writes to banks 0, 1, 3, 6 and 7, the last crossing the address top
    foreach (bw[i]) begin
      wa = {};
      wd = {};
      a = {bw[i][2:0], 8'hFF};
      host.frame('{bw[i], 8'hFF, 8'h3C, 8'hC3}, rx);
      chk(16'(wa.size()), 16'h0002);
      chk(wa[0], a);
      chk(wa[1], 11'(a + 11'h001));
      chk(wd[0], 16'h003C);
      chk(wd[1], 16'h00C3);
    end
    $display("test block write done");
    // Random write pairs address and data
    wa = {};
    wd = {};
    host.frame('{8'h0B, 8'h10, 8'hA1, 8'h20, 8'hB2}, rx);
    chk(wa[0], 16'h0310);
    chk(wd[0], 16'h00A1);
    chk(wa[1], 16'h0320);
    chk(wd[1], 16'h00B2);
    $display("test random write done");
    // Block read: dummy byte returns status, then data per byte
    ra = {};
    host.frame('{8'h3B, 8'h5A, NO_OP_BYTE, NO_OP_BYTE, NO_OP_BYTE}, rx);
    chk(rx[2], stat(1'b1));
    chk(rx[3], 16'h0000);
    chk(rx[4], 16'h0001);
    chk(ra[0], 16'h035A);
    $display("test block read done");
    // Random read; data two bytes after each address
    host.frame('{8'h2B, 8'h11, 8'h22, NO_OP_BYTE, NO_OP_BYTE}, rx);
    chk(rx[3], 16'h004B);
    chk(rx[4], 16'h0078);
    $display("test random read done");
    test_done();
  end

  // Watchdog well beyond the expected run of under 1 ms
  initial begin
    #3_000_000;
    n_errors++;
    test_done();
  end
endmodule : tb_top
`default_nettype wire
